// File: hdl/ccr_pkg.sv
// Package with the register map, field layout and types of the calibration control block.
package ccr_pkg;

	// Register bus widths.
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;

	// Register offsets.
	localparam logic [11:0] OFS_CAL_ENABLE = 12'h061;
	localparam logic [11:0] OFS_SETUP_MAIN = 12'h062;
	localparam logic [11:0] OFS_STATE_FLAGS = 12'h06a;
	localparam logic [11:0] OFS_PIN_SETUP = 12'h06b;
	localparam logic [11:0] OFS_SOFT_KICK = 12'h06c;
	localparam logic [11:0] OFS_IRQ_STATUS = 12'h070;
	localparam logic [11:0] OFS_IRQ_MASK = 12'h071;

	// Reset values.
	localparam logic [7:0] RST_CAL_ENABLE = 8'h01;
	localparam logic [7:0] RST_SETUP_MAIN = 8'h01;
	localparam logic [7:0] RST_PIN_SETUP = 8'h00;
	localparam logic [7:0] RST_SOFT_KICK = 8'h01;
	localparam logic [1:0] RST_IRQ_MASK = 2'h0;

	// Field positions in the main setup register.
	localparam int BIT_FG = 0;
	localparam int BIT_BG = 1;
	localparam int BIT_OS = 2;
	localparam int BIT_BGOS = 3;
	localparam int BIT_OSFILT = 4;
	localparam int SETUP_W = 5;

	// Field positions in the pin setup register.
	localparam int BIT_TRIG_SRC = 0;
	localparam int BIT_PINSEL_LO = 1;
	localparam int BIT_PINSEL_HI = 2;

	// Status and interrupt bit positions.
	localparam int BIT_FG_COMPLETE = 0;
	localparam int BIT_STOPPED = 1;

	// Status pin selections.
	localparam logic [1:0] PINSEL_FG_COMPLETE = 2'h0;
	localparam logic [1:0] PINSEL_ALARM = 2'h2;
	localparam logic [1:0] PINSEL_LOW = 2'h3;

	// Stand-in durations of the calibration phases, in clock cycles.
	localparam logic [7:0] FG_RUN_CYCLES = 8'h10;
	localparam logic [7:0] BG_PHASE_CYCLES = 8'h08;

	// Sequencer states, Gray coded along the usual path.
	typedef enum logic [2:0] {
		ST_HOLD = 3'h0,
		ST_WAIT = 3'h1,
		ST_CLEAR = 3'h3,
		ST_FG = 3'h2,
		ST_BG = 3'h6,
		ST_STOP = 3'h7,
		ST_DONE = 3'h5
	} ccr_state_t;

	// Control levels handed to the calibration engine.
	typedef struct packed {
		logic clearValues;
		logic fgActive;
		logic bgActive;
		logic fgOffsetEn;
		logic bgOffsetEn;
		logic offsetFilterEn;
		logic dividerResetN;
	} ccr_engine_t;

endpackage

// File: hdl/ccr_calibration_control.sv
// Calibration control and status registers with trigger selection and status pin.
module ccr_calibration_control
	import ccr_pkg::*;
(
	input wire logic refClk,
	input wire logic resetN,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [DATA_W-1:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [DATA_W-1:0] regRdata,
	input wire logic hardwareTriggerInput,
	input wire logic alarmIn,
	output logic statusOutputPin,
	output logic irq,
	output ccr_engine_t engine
);

	// Whole state of the block in one record.
	typedef struct packed {
		// Sequencer state.
		ccr_state_t state;
		// Phase timer of the sequencer.
		logic [7:0] cnt;
		// Calibration enable bit; low holds the sequencer in reset.
		logic calEnable;
		// Main setup fields: filter, offsets, background, foreground.
		logic [SETUP_W-1:0] setup;
		// Status pin source selection.
		logic [1:0] pinSel;
		// Trigger source; high takes the hardware pin.
		logic trigSource;
		// Software copy of the trigger input.
		logic softwareTriggerBit;
		// First synchroniser stage, read only by the second.
		logic trigMeta;
		// Second synchroniser stage, the usable hardware trigger.
		logic trigSync;
		// Foreground calibration has completed.
		logic fgDone;
		// Calibration has stopped.
		logic stopped;
		// Sticky event bits, cleared by writing ones.
		logic [1:0] irqStatus;
		// Event bits allowed onto the interrupt line.
		logic [1:0] irqMask;
		// Read data, valid for one cycle after a read strobe.
		logic [DATA_W-1:0] rdata;
		// Registered status pin level.
		logic pin;
		// Registered interrupt level.
		logic irq;
		// Control levels for the calibration engine.
		ccr_engine_t engine;
	} ccr_regs_t;

	// Registered state and its next value.
	ccr_regs_t s_q;
	ccr_regs_t s_d;

	// Address compare used by every register decode.
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
		hit = (a == ofs);
	endfunction

	// Next-state logic: bus, synchroniser, sequencer, flags and outputs.
	always_comb begin
		// Selected calibration trigger.
		logic trig;
		// Foreground completion event of this cycle.
		logic evFgDone;
		// Stop event of this cycle.
		logic evStopped;
		// Status bits that software clears this cycle.
		logic [1:0] w1c;
		// Hold every register unless a branch below changes it.
		s_d = s_q;
		// No trigger and no event unless found below.
		trig = 1'b0;
		evFgDone = 1'b0;
		evStopped = 1'b0;
		w1c = 2'h0;

		s_d.trigMeta = hardwareTriggerInput;
		s_d.trigSync = s_q.trigMeta;

		if (s_q.trigSource) begin
			trig = s_q.trigSync;
		end else begin
			trig = s_q.softwareTriggerBit;
		end

		// Register writes; software is expected to reprogram setup while disabled.
		if (regWr) begin
			// Enable bit; clearing it holds calibration in reset.
			if (hit(regAddr, OFS_CAL_ENABLE)) begin
				s_d.calEnable = regWdata[0];
			end
			// Main setup; the unused upper bits are dropped.
			if (hit(regAddr, OFS_SETUP_MAIN)) begin
				s_d.setup = regWdata[SETUP_W-1:0];
			end
			// Trigger source and status pin selection.
			if (hit(regAddr, OFS_PIN_SETUP)) begin
				s_d.trigSource = regWdata[BIT_TRIG_SRC];
				s_d.pinSel = regWdata[BIT_PINSEL_HI:BIT_PINSEL_LO];
			end
			if (hit(regAddr, OFS_SOFT_KICK)) begin
				s_d.softwareTriggerBit = regWdata[0];
			end
			// Write-one-to-clear of the sticky event bits.
			if (hit(regAddr, OFS_IRQ_STATUS)) begin
				w1c = regWdata[BIT_STOPPED:BIT_FG_COMPLETE];
			end
			// Interrupt mask, same layout as the event bits.
			if (hit(regAddr, OFS_IRQ_MASK)) begin
				s_d.irqMask = regWdata[BIT_STOPPED:BIT_FG_COMPLETE];
			end
		end

		// Read data appear in the cycle after the strobe only.
		s_d.rdata = '0;
		if (regRd) begin
			if (hit(regAddr, OFS_CAL_ENABLE)) begin
				// Enable bit alone.
				s_d.rdata = {7'h00, s_q.calEnable};
			end else if (hit(regAddr, OFS_SETUP_MAIN)) begin
				// Setup fields, unused bits as zero.
				s_d.rdata = {3'h0, s_q.setup};
			end else if (hit(regAddr, OFS_STATE_FLAGS)) begin
				s_d.rdata = {6'h00, s_q.stopped, s_q.fgDone};
			end else if (hit(regAddr, OFS_PIN_SETUP)) begin
				// Pin selection above the trigger source.
				s_d.rdata = {5'h00, s_q.pinSel, s_q.trigSource};
			end else if (hit(regAddr, OFS_SOFT_KICK)) begin
				// Software trigger bit alone.
				s_d.rdata = {7'h00, s_q.softwareTriggerBit};
			end else if (hit(regAddr, OFS_IRQ_STATUS)) begin
				// Sticky event bits.
				s_d.rdata = {6'h00, s_q.irqStatus};
			end else if (hit(regAddr, OFS_IRQ_MASK)) begin
				// Event mask.
				s_d.rdata = {6'h00, s_q.irqMask};
			end else begin
				// Unmapped addresses read as zero.
				s_d.rdata = '0;
			end
		end

		// Default phase counter advance.
		s_d.cnt = s_q.cnt + 8'h01;
		s_d.engine.clearValues = 1'b0;

		// Calibration sequencer.
		case (s_q.state)
			// Held in reset until enabled.
			ST_HOLD: begin
				s_d.cnt = '0;
				if (s_q.calEnable) begin
					s_d.state = ST_WAIT;
				end
			end
			// Wait for the selected trigger to go high.
			ST_WAIT: begin
				s_d.cnt = '0;
				if (trig) begin
					s_d.state = ST_CLEAR;
				end
			end
			ST_CLEAR: begin
				s_d.engine.clearValues = 1'b1;
				s_d.cnt = '0;
				s_d.fgDone = 1'b0;
				s_d.stopped = 1'b0;
				if (s_q.setup[BIT_FG]) begin
					s_d.state = ST_FG;
				end else if (s_q.setup[BIT_BG]) begin
					s_d.state = ST_BG;
				end else begin
					s_d.stopped = 1'b1;
					evStopped = 1'b1;
					s_d.state = ST_DONE;
				end
			end
			// Foreground calibration runs for a fixed time.
			ST_FG: begin
				if (s_q.cnt == FG_RUN_CYCLES - 8'h01) begin
					s_d.fgDone = 1'b1;
					evFgDone = 1'b1;
					s_d.cnt = '0;
					if (s_q.setup[BIT_BG]) begin
						s_d.state = ST_BG;
					end else begin
						s_d.stopped = 1'b1;
						evStopped = 1'b1;
						s_d.state = ST_DONE;
					end
				end
			end
			ST_BG: begin
				if (s_q.cnt == BG_PHASE_CYCLES - 8'h01) begin
					s_d.cnt = '0;
					if (!trig) begin
						s_d.stopped = 1'b1;
						evStopped = 1'b1;
						s_d.state = ST_STOP;
					end
				end
			end
			// Halted at a phase boundary until the trigger returns.
			ST_STOP: begin
				s_d.cnt = '0;
				if (trig) begin
					s_d.stopped = 1'b0;
					s_d.state = ST_BG;
				end
			end
			// Calibration finished with background off.
			ST_DONE: begin
				s_d.cnt = '0;
			end
			default: begin
				// Unused state codes recover to hold.
				s_d.state = ST_HOLD;
				s_d.cnt = '0;
			end
		endcase

		if (!s_q.calEnable) begin
			s_d.state = ST_HOLD;
			s_d.cnt = '0;
		end
		// Divider reset follows the enable bit one cycle later.
		s_d.engine.dividerResetN = s_q.calEnable;

		// Phase levels for the engine.
		s_d.engine.fgActive = (s_d.state == ST_FG);
		s_d.engine.bgActive = (s_d.state == ST_BG);

		s_d.engine.offsetFilterEn = s_q.setup[BIT_OSFILT];
		s_d.engine.bgOffsetEn = s_q.setup[BIT_BGOS] & s_q.setup[BIT_BG];
		s_d.engine.fgOffsetEn = s_q.setup[BIT_OS] & s_q.setup[BIT_FG];

		// Sticky interrupt flags; a new event wins over a clear in the same cycle.
		s_d.irqStatus = (s_q.irqStatus & ~w1c) | {evStopped, evFgDone};
		s_d.irq = |(s_d.irqStatus & s_d.irqMask);

		// Status pin source selection.
		case (s_d.pinSel)
			PINSEL_FG_COMPLETE: begin
				s_d.pin = s_d.fgDone;
			end
			PINSEL_ALARM: begin
				s_d.pin = alarmIn;
			end
			PINSEL_LOW: begin
				s_d.pin = 1'b0;
			end
			default: begin
				// Reserved selection drives low.
				s_d.pin = 1'b0;
			end
		endcase
	end

	// State register with asynchronous active-low reset.
	always_ff @(posedge refClk or negedge resetN) begin
		if (!resetN) begin
			s_q.state <= ST_HOLD;
			s_q.cnt <= '0;
			s_q.calEnable <= RST_CAL_ENABLE[0];
			s_q.setup <= RST_SETUP_MAIN[SETUP_W-1:0];
			s_q.pinSel <= RST_PIN_SETUP[BIT_PINSEL_HI:BIT_PINSEL_LO];
			s_q.trigSource <= RST_PIN_SETUP[BIT_TRIG_SRC];
			s_q.softwareTriggerBit <= RST_SOFT_KICK[0];
			// Synchroniser starts at the idle level of the pin.
			s_q.trigMeta <= 1'b0;
			s_q.trigSync <= 1'b0;
			// Status and event bits start clear.
			s_q.fgDone <= 1'b0;
			s_q.stopped <= 1'b0;
			s_q.irqStatus <= 2'h0;
			s_q.irqMask <= RST_IRQ_MASK;
			// Outputs are low during reset.
			s_q.rdata <= '0;
			s_q.pin <= 1'b0;
			s_q.irq <= 1'b0;
			s_q.engine <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs come straight from the state register.
	// Read data bus.
	assign regRdata = s_q.rdata;
	// Status pin level.
	assign statusOutputPin = s_q.pin;
	// Interrupt line.
	assign irq = s_q.irq;
	// Engine control levels.
	assign engine = s_q.engine;

endmodule

// File: test/ccr_calibration_control_monitor.sv
// Port checker for the calibration control block, bound to the design below.
module ccr_calibration_control_monitor
	import ccr_pkg::*;
(
	input wire logic refClk,
	input wire logic resetN,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [DATA_W-1:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [DATA_W-1:0] regRdata,
	input wire logic hardwareTriggerInput,
	input wire logic alarmIn,
	input wire logic statusOutputPin,
	input wire logic irq,
	input wire ccr_engine_t engine
);
	// Mirror of the pin select field, kept from the bus writes.
	logic [1:0] selQ;
	// Number of cycles the foreground run has lasted so far.
	logic [7:0] fgLenQ;

	// Track the select field and time the foreground run.
	always_ff @(posedge refClk or negedge resetN) begin
		if (!resetN) begin
			selQ <= 2'h0;
			fgLenQ <= 8'h00;
		end else begin
			if (regWr && regAddr == OFS_PIN_SETUP) begin
				selQ <= regWdata[2:1];
			end
			fgLenQ <= engine.fgActive ? fgLenQ + 8'h01 : 8'h00;
		end
	end

	default clocking @(posedge refClk); endclocking
	default disable iff (!resetN);

	// A write to the main setup register.
	sequence setupWr;
		regWr && regAddr == OFS_SETUP_MAIN;
	endsequence

	a_filter_follows: assert property (setupWr |-> ##2
		engine.offsetFilterEn == $past(regWdata[4], 2)) else $error("offset filter wrong");
	a_bg_offset_gate: assert property (setupWr |-> ##2
		engine.bgOffsetEn == ($past(regWdata[3], 2) && $past(regWdata[1], 2)))
		else $error("background offset wrong");
	a_fg_offset_gate: assert property (setupWr |-> ##2
		engine.fgOffsetEn == ($past(regWdata[2], 2) && $past(regWdata[0], 2)))
		else $error("foreground offset wrong");
	a_clear_once: assert property (engine.clearValues |=> !engine.clearValues)
		else $error("clear pulse too long");
	a_fg_length: assert property ($fell(engine.fgActive) && engine.dividerResetN
		|-> fgLenQ == FG_RUN_CYCLES) else $error("foreground run length wrong");
	a_pin_alarm: assert property (selQ == PINSEL_ALARM && $past(selQ) == PINSEL_ALARM
		|-> statusOutputPin == $past(alarmIn)) else $error("pin not following alarm");
	a_pin_low: assert property (selQ == PINSEL_LOW && $past(selQ) == PINSEL_LOW
		|-> !statusOutputPin) else $error("pin not held low");
	a_div_reset: assert property (regWr && regAddr == OFS_CAL_ENABLE |-> ##2
		engine.dividerResetN == $past(regWdata[0], 2)) else $error("divider reset wrong");
	a_hold_quiet: assert property (!engine.dividerResetN && $past(engine.dividerResetN) == 1'b0
		|-> !engine.fgActive && !engine.bgActive) else $error("run while disabled");
endmodule

bind ccr_calibration_control ccr_calibration_control_monitor mon (.refClk, .resetN, .regAddr,
	.regWdata, .regWr, .regRd, .regRdata, .hardwareTriggerInput, .alarmIn, .statusOutputPin,
	.irq, .engine);

// File: test/ccr_ext_controller.sv
// Model of the outside controller that drives the hardware trigger pin.
module ccr_ext_controller
	import ccr_pkg::*;
(
	input wire logic refClk,
	input wire logic resetN,
	input wire logic goReq,
	input wire logic [3:0] lag,
	output logic trigOut
);
	timeunit 1ns;
	timeprecision 1ns;
	// Cycles left before the pin follows the request.
	logic [3:0] cntQ;

	// delayed hardware trigger
	// The pin follows the request after a settable delay, prompt or slow.
	always_ff @(posedge refClk or negedge resetN) begin
		if (!resetN) begin
			cntQ <= 4'h0;
			trigOut <= 1'b0;
		end else if (trigOut == goReq) begin
			cntQ <= lag;
		end else if (cntQ == 4'h0) begin
			trigOut <= goReq;
		end else begin
			cntQ <= cntQ - 4'h1;
		end
	end
endmodule

// File: test/ccr_calibration_control_bench.sv
// Self-checking bench of the calibration control block.
module ccr_calibration_control_bench
	import ccr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic refClk = 1'b0;
	logic resetN = 1'b0;
	logic [ADDR_W-1:0] regAddr = 12'h000;
	logic [DATA_W-1:0] regWdata = 8'h00;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic alarmIn = 1'b0;
	logic goReq = 1'b0;
	logic [DATA_W-1:0] regRdata;
	logic hardwareTriggerInput, statusOutputPin, irq;
	ccr_engine_t engine;
	int fails = 0;
	int nTests = 0;
	int cycles = 0;
	// Rows of address beside expected reset value.
	logic [19:0] rows [6];

	always #25 refClk = ~refClk;

	ccr_calibration_control DUT (.refClk, .resetN, .regAddr, .regWdata, .regWr, .regRd,
		.regRdata, .hardwareTriggerInput, .alarmIn, .statusOutputPin, .irq, .engine);
	ccr_ext_controller far (.refClk, .resetN, .goReq, .lag(4'h3), .trigOut(hardwareTriggerInput));

	task automatic cyc(input int n);
		repeat (n) @(posedge refClk);
	endtask
	task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		nTests++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk1(input string what, input logic exp, input logic got);
		#1 chk8(what, {7'h00, exp}, {7'h00, got});
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge refClk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge refClk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string what);
		@(posedge refClk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge refClk);
		regRd <= 1'b0;
		#1 chk8(what, exp, regRdata);
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", nTests, fails);
		if (fails == 0 && nTests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Cut a hang short.
	always @(posedge refClk) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			wrap_up();
		end
	end

	initial begin
		rows = '{{OFS_CAL_ENABLE, RST_CAL_ENABLE}, {OFS_SETUP_MAIN, RST_SETUP_MAIN},
			{OFS_PIN_SETUP, RST_PIN_SETUP}, {OFS_SOFT_KICK, RST_SOFT_KICK},
			{OFS_IRQ_MASK, 6'h00, RST_IRQ_MASK}, {12'h0ff, 8'h00}};
		cyc(3);
		resetN <= 1'b1;
		foreach (rows[i]) rd(rows[i][19:8], rows[i][7:0], "reset value");
		$display("reset test done");
		cyc(40);
		rd(OFS_STATE_FLAGS, 8'h03, "status after start");
		chk1("irq masked", 1'b0, irq);
		wr(OFS_IRQ_MASK, 8'h03);
		cyc(2);
		chk1("irq raised", 1'b1, irq);
		wr(OFS_IRQ_STATUS, 8'h01);
		rd(OFS_IRQ_STATUS, 8'h02, "irq status");
		wr(OFS_IRQ_MASK, 8'h01);
		cyc(2);
		chk1("irq off", 1'b0, irq);
		chk1("pin done", 1'b1, statusOutputPin);
		wr(OFS_PIN_SETUP, 8'h06);
		cyc(2);
		chk1("pin low", 1'b0, statusOutputPin);
		wr(OFS_PIN_SETUP, 8'h04);
		alarmIn <= 1'b1;
		cyc(2);
		chk1("pin alarm", 1'b1, statusOutputPin);
		wr(OFS_PIN_SETUP, 8'h02);
		cyc(2);
		chk1("pin reserved", 1'b0, statusOutputPin);
		$display("status and pin test done");
		wr(OFS_CAL_ENABLE, 8'h00);
		wr(OFS_PIN_SETUP, 8'h01);
		wr(OFS_CAL_ENABLE, 8'h01);
		cyc(20);
		chk1("hw idle", 1'b0, engine.fgActive);
		cyc(1);
		goReq <= 1'b1;
		cyc(10);
		chk1("hw start", 1'b1, engine.fgActive);
		cyc(30);
		wr(OFS_CAL_ENABLE, 8'h00);
		wr(OFS_PIN_SETUP, 8'h00);
		wr(OFS_SOFT_KICK, 8'h00);
		wr(OFS_CAL_ENABLE, 8'h01);
		cyc(20);
		chk1("sw idle", 1'b0, engine.fgActive);
		wr(OFS_SOFT_KICK, 8'h01);
		cyc(4);
		chk1("sw start", 1'b1, engine.fgActive);
		cyc(30);
		$display("trigger test done");
		wr(OFS_CAL_ENABLE, 8'h00);
		wr(OFS_SETUP_MAIN, 8'h0f);
		wr(OFS_CAL_ENABLE, 8'h01);
		cyc(40);
		chk1("bg running", 1'b1, engine.bgActive);
		rd(OFS_STATE_FLAGS, 8'h01, "bg status");
		wr(OFS_SOFT_KICK, 8'h00);
		cyc(20);
		rd(OFS_STATE_FLAGS, 8'h03, "bg halted");
		wr(OFS_SOFT_KICK, 8'h01);
		cyc(3);
		rd(OFS_STATE_FLAGS, 8'h01, "bg resumed");
		wr(OFS_CAL_ENABLE, 8'h00);
		wr(OFS_SETUP_MAIN, 8'h14);
		wr(OFS_CAL_ENABLE, 8'h01);
		cyc(10);
		rd(OFS_STATE_FLAGS, 8'h02, "fg skipped");
		$display("background test done");
		wrap_up();
	end
endmodule
